// [src/passthru_passive_byte_steering.sv]
`timescale 1ns/1ns

// Posted-write buffer between the PCI side and the add-on data register
module pt_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          in_ready;
	} fifo_s;

	fifo_s            s;
	fifo_s            next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// Ready is a flop so the source sees a clean back-pressure level
	assign in_ready  = s.in_ready;
	assign out_valid = s.cnt != '0;
	assign out_data  = mem[s.rp];
	assign push      = in_valid && s.in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap naturally; depth is a power of two
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.wp = AW'(s.wp + 1'b1);
		end
		if (pop) begin
			next_s.rp = AW'(s.rp + 1'b1);
		end
		next_s.cnt      = (AW+1)'(s.cnt + push - pop);
		next_s.in_ready = next_s.cnt != (AW+1)'(DEPTH);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Storage needs no reset, the count guards it
	always_ff @(posedge clk) begin
		if (push) begin
			mem[s.wp] <= in_data;
		end
	end

endmodule : pt_fifo

// Passive pass-thru data path on the add-on side
module passthru_passive_byte_steering (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             addon_rd_n,
	input  wire logic             addon_wr_n,
	input  wire logic             select_n,
	input  wire logic [4:0]       reg_addr,
	input  wire logic [3:0]       addon_byte_enable_n,
	input  wire logic             addon_ready_n,
	input  wire logic             address_output_n,
	input  wire logic [31:0]      dq_in,
	output logic      [31:0]      dq_out,
	output logic                  dq_oe_n,
	output logic                  attention_n,
	output logic                  burst_pending_n,
	output logic      [1:0]       region_index,
	output logic                  pci_write_dir,
	output logic      [3:0]       requested_byte_n,
	input  wire logic             bus_width_strap,
	input  wire logic             active_mode_strap,
	input  wire logic [31:0]      region_control,
	input  wire logic [7:0]       region_width,
	input  wire pt_pkg::pci_req_s pci_req,
	input  wire logic             pci_start,
	output logic                  pci_req_ready,
	input  wire pt_pkg::wdata_s   pci_wdata,
	input  wire logic             pci_wvalid,
	output logic                  pci_wready,
	output logic      [31:0]      pci_rdata,
	output logic                  pci_rvalid,
	input  wire logic             pci_rready
);
	import pt_pkg::*;

	typedef struct packed {
		pt_state_e   st;
		logic        strap_done;
		logic        passive;
		logic        attn_n;
		logic        burst_n;
		logic [1:0]  region;
		logic        wr;
		logic [3:0]  req_n;
		logic [3:0]  pci_be_n;
		logic [7:0]  left;
		logic [31:0] addr;
		logic [31:0] data;
		logic [31:0] dq;
		logic        dq_oe_n;
		logic        rvalid;
		logic [31:0] rdata;
		logic        req_ready;
	} core_s;

	core_s       s;
	core_s       next_s;
	wdata_s      head;
	logic        head_valid;
	logic        pop;
	logic        done;
	logic        data_hit;
	logic        addr_hit;
	logic [1:0]  width;
	logic [1:0]  swap;
	logic [3:0]  be_a;
	logic [31:0] dq_a;

	pt_fifo #(
		.WIDTH ($bits(wdata_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_data   (pci_wdata),
		.in_valid  (pci_wvalid),
		.in_ready  (pci_wready),
		.out_data  (head),
		.out_valid (head_valid),
		.out_ready (pop)
	);

	// Region width and endian swap of the region now under attention
	always_comb begin
		width = region_width[2*int'(s.region) +: 2];
		swap  = SWAP_NONE;
		if (region_control[ENDIAN_BIT0 + ENDIAN_STRIDE*int'(s.region)]) begin
			swap = (width == WIDTH_32) ? SWAP_32 :
			       (width == WIDTH_16) ? SWAP_16 : SWAP_NONE;
		end
	end

	// Endian conversion sits in front of the data-register steering, data and enables
	assign be_a     = be_swap(~addon_byte_enable_n, swap);
	assign dq_a     = lane_swap(dq_in, swap);
	assign data_hit = !select_n && {reg_addr, 2'b00} == OFS_DATA;
	assign addr_hit = !select_n && {reg_addr, 2'b00} == OFS_ADDRESS;
	// A read completion stalls while the PCI side holds the last dword
	assign done = s.st == ST_XFER && !addon_ready_n &&
	              !(s.rvalid && !pci_rready);
	// Next posted dword is taken straight on completion to save a cycle
	// A count of one means the last dword, so only pop while more remain
	assign pop  = head_valid && (s.st == ST_LOAD ||
	              (done && s.wr && s.left > 8'h1));

	always_comb begin
		int low;
		logic [31:0] rd;
		next_s         = s;
		low            = 0;
		rd             = 32'h0;
		next_s.dq_oe_n = 1'b1;
		if (pci_rready) begin
			next_s.rvalid = 1'b0;
		end
		// Mode strap is caught once, on the first edge after reset
		if (!s.strap_done) begin
			next_s.strap_done = 1'b1;
			next_s.passive    = active_mode_strap;
		end
		// Address reads never look at the region widths
		if (!address_output_n) begin
			next_s.dq      = s.addr;
			next_s.dq_oe_n = 1'b0;
		end else if (addr_hit && !addon_rd_n) begin
			next_s.dq_oe_n = 1'b0;
			if (bus_width_strap) begin
				next_s.dq = s.addr;
			end else if (!addon_byte_enable_n[3]) begin
				next_s.dq = {16'h0, s.addr[15:0]};
			end else begin
				next_s.dq = {16'h0, s.addr[31:16]};
			end
		end else if (data_hit && !addon_rd_n && s.st == ST_XFER) begin
			// Lowest enabled byte is copied down to the low lanes
			for (int i = 3; i >= 0; i--) begin
				if (be_a[i]) begin
					low = i;
				end
			end
			for (int j = 0; j < 4; j++) begin
				rd[j*8 +: 8] = (j <= low) ? s.data[low*8 +: 8] :
				               s.data[j*8 +: 8];
			end
			next_s.dq      = lane_swap(rd, swap);
			next_s.dq_oe_n = 1'b0;
			if (s.wr) begin
				next_s.req_n = s.req_n | be_a;
			end
		end
		// Add-on writes fill only bytes both requested and enabled
		if (data_hit && !addon_wr_n && s.st == ST_XFER && !s.wr) begin
			for (int i = 0; i < 4; i++) begin
				if (be_a[i] && !s.req_n[i]) begin
					next_s.data[i*8 +: 8] =
						(width == WIDTH_32) ? dq_a[i*8 +: 8] :
						(width == WIDTH_16) ? dq_a[(i%2)*8 +: 8] :
						dq_a[7:0];
					next_s.req_n[i] = 1'b1;
				end
			end
		end
		case (s.st)
			ST_IDLE: begin
				next_s.req_ready = s.passive && s.strap_done;
				if (pci_start && s.req_ready) begin
					next_s.req_ready = 1'b0;
					next_s.addr      = pci_req.addr;
					next_s.region    = pci_req.region;
					next_s.wr        = pci_req.write;
					next_s.left      = pci_req.dwords;
					next_s.pci_be_n  = pci_req.be_n;
					if (pci_req.write) begin
						next_s.st = ST_LOAD;
					end else begin
						next_s.st      = ST_XFER;
						next_s.attn_n  = 1'b0;
						next_s.burst_n = !(pci_req.dwords > 8'h1);
						next_s.req_n   = pci_req.be_n;
						next_s.data    = 32'h0;
					end
				end
			end
			ST_LOAD: begin
				if (head_valid) begin
					next_s.st      = ST_XFER;
					next_s.data    = head.data;
					next_s.req_n   = head.be_n;
					next_s.attn_n  = 1'b0;
					next_s.burst_n = !(s.left > 8'h1);
				end
			end
			ST_XFER: begin
				if (done) begin
					next_s.left = 8'(s.left - 8'h1);
					if (!s.wr) begin
						next_s.rvalid = 1'b1;
						next_s.rdata  = next_s.data;
					end
					if (s.left <= 8'h1) begin
						next_s.st      = ST_IDLE;
						next_s.attn_n  = 1'b1;
						next_s.burst_n = 1'b1;
						next_s.req_n   = REQ_NONE;
					end else begin
						next_s.burst_n = !(s.left > 8'h2);
						if (!s.wr) begin
							next_s.req_n = s.pci_be_n;
							next_s.data  = 32'h0;
						end else if (head_valid) begin
							next_s.data  = head.data;
							next_s.req_n = head.be_n;
						end else begin
							next_s.st    = ST_LOAD;
							next_s.req_n = REQ_NONE;
						end
					end
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
	end

	// Status changes only at the points above while attention holds
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s         <= '0;
			s.st      <= ST_IDLE;
			s.attn_n  <= 1'b1;
			s.burst_n <= 1'b1;
			s.req_n   <= REQ_NONE;
			s.dq_oe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign dq_out           = s.dq;
	assign dq_oe_n          = s.dq_oe_n;
	assign attention_n      = s.attn_n;
	assign burst_pending_n  = s.burst_n;
	assign region_index     = s.region;
	assign pci_write_dir    = s.wr;
	assign requested_byte_n = s.req_n;
	assign pci_req_ready    = s.req_ready;
	assign pci_rdata        = s.rdata;
	assign pci_rvalid       = s.rvalid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence write_hit_lane0;
		data_hit && !addon_wr_n && s.st == ST_XFER && !s.wr && be_a[0];
	endsequence

	sequence lane0_held;
		s.st == ST_XFER && s.req_n[0] && addon_ready_n;
	endsequence

	a_unrequested_byte_kept: assert property (
		lane0_held |=> s.data[7:0] == $past(s.data[7:0]))
		else $error("unrequested byte 0 changed");

	a_written_byte_drops: assert property (
		write_hit_lane0 ##0 !s.req_n[0] ##0 addon_ready_n
		|=> requested_byte_n[0])
		else $error("written byte still requested");

	a_address_pin_out: assert property (
		!address_output_n |=> !dq_oe_n && dq_out == $past(s.addr))
		else $error("address not driven for address pin");

	a_address_low_half: assert property (
		address_output_n && addr_hit && !addon_rd_n && !bus_width_strap &&
		!addon_byte_enable_n[3] |=> dq_out[15:0] == $past(s.addr[15:0]))
		else $error("low address half wrong");

	a_last_dword_ends: assert property (
		done && s.left == 8'h1 |=> attention_n && burst_pending_n &&
		requested_byte_n == REQ_NONE)
		else $error("transfer end not signalled");

	a_burst_drops_last: assert property (
		done && s.left == 8'h2 |=> burst_pending_n && !attention_n)
		else $error("burst not dropped with one dword left");

	a_read_start_status: assert property (
		pci_start && pci_req_ready && !pci_req.write |=> !attention_n &&
		region_index == $past(pci_req.region) && !pci_write_dir)
		else $error("read access status not presented");

	a_status_held: assert property (
		!attention_n ##1 !attention_n |-> $stable(region_index) &&
		$stable(pci_write_dir))
		else $error("status changed under attention");

endmodule : passthru_passive_byte_steering

// [src/pt_pkg.sv]
// What this block does
// - Byte written only when requested and enabled
// - Written byte drops its requested-byte output
// - Eight-bit region: byte enable picks target byte
// - Write lanes steered by region bus width
// - Read: lowest enabled byte fills lower lanes
// - Address pin drives full 32-bit address
// - Address register readable at 28h, one cycle
// - Sixteen-bit strap: byte enable 3 picks half
// - Address reads ignore region bus widths
// - Status outputs update the clock after access
// - Status outputs valid only under attention
// - Burst, region and direction describe the access
// - Eight-bit read: byte on low lane, request drops
// - Ready completes dword, pops FIFO, refreshes requests
// - Burst drops when one dword remains
// - No data left: attention off, requests Fh
// - After low word, only high bytes requested
// - Per-region endian bit in region control
// - Big endian 32-bit reverses byte order
// - Strap low selects active mode, else passive
// - Sixteen-bit region needs two word cycles
package pt_pkg;

	// Operation register byte addresses
	localparam logic [6:0] OFS_ADDRESS = 7'h28;
	localparam logic [6:0] OFS_DATA    = 7'h2c;

	// Region bus widths, two bits per region
	localparam logic [1:0] WIDTH_8  = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;

	// Endian select bits in the region control word
	localparam int ENDIAN_BIT0   = 6;
	localparam int ENDIAN_STRIDE = 8;

	localparam logic [3:0] REQ_NONE   = 4'hf;
	localparam logic [1:0] SWAP_32    = 2'h3;
	localparam logic [1:0] SWAP_16    = 2'h1;
	localparam logic [1:0] SWAP_NONE  = 2'h0;
	localparam int         FIFO_DEPTH = 4;

	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_XFER} pt_state_e;

	// One access as announced by the PCI side
	typedef struct packed {
		logic [31:0] addr;
		logic [1:0]  region;
		logic        write;
		logic [7:0]  dwords;
		logic [3:0]  be_n;
	} pci_req_s;

	// One posted dword with its byte enables
	typedef struct packed {
		logic [3:0]  be_n;
		logic [31:0] data;
	} wdata_s;

	// Byte i of the result is byte i^k of the input
	function automatic logic [31:0] lane_swap(logic [31:0] d, logic [1:0] k);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 4; i++) begin
			r[i*8 +: 8] = d[(i ^ int'(k))*8 +: 8];
		end
		return r;
	endfunction : lane_swap

	function automatic logic [3:0] be_swap(logic [3:0] b, logic [1:0] k);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 4; i++) begin
			r[i] = b[i ^ int'(k)];
		end
		return r;
	endfunction : be_swap

endpackage : pt_pkg

// [verif/addon_model.sv]
`timescale 1ns/1ns

// Add-on local bus logic; one call of cyc is one bus cycle
module addon_model (
	input  wire logic   clk,
	output logic        addon_rd_n,
	output logic        addon_wr_n,
	output logic        select_n,
	output logic [4:0]  reg_addr,
	output logic [3:0]  addon_byte_enable_n,
	output logic        addon_ready_n,
	output logic        address_output_n,
	output logic [31:0] dq_in
);
	logic [31:0] last;

	// Quiet bus from time zero
	initial begin
		{addon_rd_n, addon_wr_n, select_n, addon_ready_n} = 4'hf;
		address_output_n = 1'b1;
		reg_addr = 5'h0;
		addon_byte_enable_n = 4'hf;
		dq_in = 32'h0;
		last = 32'h0;
	end

	// Launch off the falling edge and hold for one full cycle
	task automatic cyc(input logic rd, input logic wr, input logic rdy,
		input logic adr, input logic [4:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clk);
		addon_rd_n <= ~rd;
		addon_wr_n <= ~wr;
		select_n <= ~(rd | wr);
		addon_ready_n <= ~rdy;
		address_output_n <= ~adr;
		reg_addr <= a;
		addon_byte_enable_n <= be;
		// Released bus shows the inverse, so stale data can never match
		if (wr) begin
			dq_in <= d;
			last = d;
		end else begin
			dq_in <= ~last;
		end
	endtask : cyc
endmodule : addon_model

// [verif/tb_passthru_passive_byte_steering.sv]
`timescale 1ns/1ns

module tb_passthru_passive_byte_steering;
	import pt_pkg::*;

	logic        clk = 1'b0;
	logic        nrst;
	logic        addon_rd_n, addon_wr_n, select_n, addon_ready_n;
	logic        address_output_n, dq_oe_n, attention_n, burst_pending_n;
	logic [4:0]  reg_addr;
	logic [3:0]  addon_byte_enable_n, requested_byte_n;
	logic [31:0] dq_in, dq_out, region_control, pci_rdata;
	logic [1:0]  region_index;
	logic        pci_write_dir, bus_width_strap, pci_start, pci_req_ready;
	logic        pci_wvalid, pci_wready, pci_rvalid, active_mode_strap;
	pci_req_s    pci_req;
	wdata_s      pci_wdata;
	logic [8:0]  st;
	logic [31:0] d0, d1, d2, a1, a2, a3;
	logic [31:0] exp_q[$], msk_q[$], rd_q[$];
	int          errors = 0;
	int          tests_run = 0;
	logic [4:0]  dreg = OFS_DATA[6:2];

	assign st = {burst_pending_n, attention_n, pci_write_dir, region_index,
		requested_byte_n};

	always #2 clk = ~clk;

	addon_model pm_u (.clk(clk), .addon_rd_n(addon_rd_n),
		.addon_wr_n(addon_wr_n), .select_n(select_n), .reg_addr(reg_addr),
		.addon_byte_enable_n(addon_byte_enable_n),
		.addon_ready_n(addon_ready_n), .address_output_n(address_output_n),
		.dq_in(dq_in));

	passthru_passive_byte_steering dut_u (.clk(clk), .nrst(nrst),
		.addon_rd_n(addon_rd_n), .addon_wr_n(addon_wr_n),
		.select_n(select_n), .reg_addr(reg_addr),
		.addon_byte_enable_n(addon_byte_enable_n),
		.addon_ready_n(addon_ready_n), .address_output_n(address_output_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.attention_n(attention_n), .burst_pending_n(burst_pending_n),
		.region_index(region_index), .pci_write_dir(pci_write_dir),
		.requested_byte_n(requested_byte_n),
		.bus_width_strap(bus_width_strap),
		.active_mode_strap(active_mode_strap),
		.region_control(region_control),
		.region_width({WIDTH_16, WIDTH_32, WIDTH_8, WIDTH_8}),
		.pci_req(pci_req), .pci_start(pci_start),
		.pci_req_ready(pci_req_ready), .pci_wdata(pci_wdata),
		.pci_wvalid(pci_wvalid), .pci_wready(pci_wready),
		.pci_rdata(pci_rdata), .pci_rvalid(pci_rvalid), .pci_rready(1'b1));

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	// Status word, with don't-care fields masked off
	task automatic chk_st(input logic [8:0] e, input logic [8:0] m);
		check("status", {23'h0, st & m}, {23'h0, e & m});
	endtask : chk_st

	// Reads note their expected bus value before the strobe goes out
	task automatic rd(input logic [4:0] a, input logic [3:0] be,
		input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		pm_u.cyc(1'b1, 1'b0, 1'b0, 1'b0, a, be, 32'h0);
	endtask : rd

	task automatic adr(input logic [31:0] e);
		exp_q.push_back(e);
		msk_q.push_back(32'hffffffff);
		pm_u.cyc(1'b0, 1'b0, 1'b0, 1'b1, 5'h0, 4'hf, 32'h0);
	endtask : adr

	task automatic wr(input logic [3:0] be, input logic [31:0] d);
		pm_u.cyc(1'b0, 1'b1, 1'b0, 1'b0, dreg, be, d);
	endtask : wr

	task automatic idle;
		pm_u.cyc(1'b0, 1'b0, 1'b0, 1'b0, 5'h0, 4'hf, 32'h0);
	endtask : idle

	task automatic ready;
		pm_u.cyc(1'b0, 1'b0, 1'b1, 1'b0, 5'h0, 4'hf, 32'h0);
	endtask : ready

	// Announce one PCI access, then wait a bounded time for attention
	task automatic start(input logic [31:0] a, input logic [1:0] r,
		input logic w);
		int n;
		repeat (2) @(negedge clk);
		pci_req <= '{addr: a, region: r, write: w, dwords: 8'h2 - 8'(!w),
			be_n: 4'h0};
		pci_start <= 1'b1;
		@(negedge clk);
		pci_start <= 1'b0;
		n = 0;
		while (attention_n !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (attention_n !== 1'b0) begin
			errors++;
			final_report();
		end
	endtask : start

	// Lowest enabled byte fills its lane and every lane below it
	function automatic logic [31:0] steer(input logic [31:0] d, input int k);
		logic [31:0] r;
		r = d;
		for (int j = 0; j <= k; j++) begin
			r[j*8 +: 8] = d[k*8 +: 8];
		end
		return r;
	endfunction : steer

	// Each drive of the bus or read completion takes the oldest note
	always @(negedge clk) begin
		if (nrst === 1'b1 && dq_oe_n === 1'b0) begin
			if (exp_q.size() == 0) begin
				check("dq_oe_n", {31'h0, dq_oe_n}, 32'h1);
			end else begin
				check("dq_out", dq_out & msk_q.pop_front(), exp_q.pop_front());
			end
		end
		if (pci_rvalid === 1'b1) begin
			if (rd_q.size() == 0) begin
				check("pci_rvalid", 32'h1, 32'h0);
			end else begin
				check("pci_rdata", pci_rdata, rd_q.pop_front());
			end
		end
	end

	initial begin
		nrst = 1'b0;
		active_mode_strap = 1'b1;
		bus_width_strap = 1'b1;
		region_control = 32'h00400000;
		pci_req = '0;
		pci_start = 1'b0;
		pci_wdata = '0;
		pci_wvalid = 1'b0;
		void'($urandom(92));
		d0 = $urandom;
		d1 = $urandom;
		d2 = $urandom;
		a1 = $urandom;
		a2 = $urandom;
		a3 = $urandom;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		chk_st(9'b110001111, 9'h1ff);
		// Two posted dwords, then a burst write to the 8-bit region 0
		@(negedge clk);
		pci_wdata <= '{be_n: 4'h0, data: d0};
		pci_wvalid <= 1'b1;
		@(negedge clk);
		pci_wdata <= '{be_n: 4'h0, data: d1};
		@(negedge clk);
		pci_wvalid <= 1'b0;
		start(a1, 2'h0, 1'b1);
		chk_st(9'b001000000, 9'h1ff);
		adr(a1);
		idle();
		for (int i = 0; i < 4; i++) begin
			rd(dreg, ~(4'h1 << i), steer(d0, i), 32'hffffffff);
		end
		idle();
		chk_st(9'b001001111, 9'h1ff);
		ready();
		idle();
		chk_st(9'b101000000, 9'h1ff);
		for (int i = 3; i >= 0; i--) begin
			rd(dreg, ~(4'h1 << i), steer(d1, i), 32'hffffffff);
		end
		ready();
		idle();
		chk_st(9'b110001111, 9'h18f);
		// PCI read from 16-bit region 3; address reads on a 16-bit strap
		start(a2, 2'h3, 1'b0);
		chk_st(9'b100110000, 9'h1ff);
		bus_width_strap = 1'b0;
		adr(a2);
		idle();
		rd(OFS_ADDRESS[6:2], 4'h7, {16'h0, a2[15:0]}, 32'h0000ffff);
		rd(OFS_ADDRESS[6:2], 4'h8, {16'h0, a2[31:16]}, 32'h0000ffff);
		// Strap may only move once the upper-half read has been sampled
		idle();
		bus_width_strap = 1'b1;
		rd(OFS_ADDRESS[6:2], 4'h0, a2, 32'hffffffff);
		wr(4'hc, {16'h0, d2[15:0]});
		idle();
		chk_st(9'b100110011, 9'h1ff);
		wr(4'hc, {16'h0, ~d2[15:0]});
		wr(4'h3, {16'h0, d2[31:16]});
		idle();
		chk_st(9'b100111111, 9'h1ff);
		rd_q.push_back(d2);
		ready();
		idle();
		idle();
		chk_st(9'b110001111, 9'h18f);
		// Big endian 32-bit region 2 swaps the byte order
		start(a3, 2'h2, 1'b0);
		wr(4'h0, d1);
		idle();
		rd_q.push_back({d1[7:0], d1[15:8], d1[23:16], d1[31:24]});
		ready();
		idle();
		idle();
		chk_st(9'b110001111, 9'h18f);
		// Second reset with the strap low: the block must stay idle
		nrst = 1'b0;
		active_mode_strap = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check("pci_req_ready", {31'h0, pci_req_ready}, 32'h0);
		check("pci_wready", {31'h0, pci_wready}, 32'h1);
		chk_st(9'b110001111, 9'h1ff);
		repeat (4) @(negedge clk);
		check("pending", 32'(exp_q.size() + rd_q.size()), 32'h0);
		final_report();
	end
endmodule : tb_passthru_passive_byte_steering
